/* File: include/dac_pkg.sv */
package dac_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [15:0] dac_code_ch0_addr = 16'hfff8;
  localparam logic [15:0] dac_code_ch1_addr = 16'hfff9;
  localparam logic [15:0] dac_control_addr = 16'hfffa;
  localparam logic [7:0] code_reset = 8'h00;
  localparam logic [7:0] control_reset = 8'h1f;
  localparam logic [4:0] control_reserved = 5'h1f;
  localparam int out_enable_ch1_bit = 7;
  localparam int out_enable_ch0_bit = 6;
  localparam int joint_convert_enable_bit = 5;
  localparam int code_width = 8;
  localparam int full_scale = 256;
  localparam int max_conv_time_ns = 10000;
  localparam int clk_period_ns = 20;
  localparam int conv_cycles = max_conv_time_ns / clk_period_ns;
  typedef enum logic [1:0] {
    apb_idle = 2'b00,
    apb_access = 2'b01
  } apb_state_t;
endpackage

/* File: logic/dac_apb_slave.sv */
module dac_apb_slave
  import dac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [7:0] rd_code_ch0,
  input wire logic [7:0] rd_code_ch1,
  input wire logic [7:0] rd_control,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wr_code_ch0,
  output logic wr_code_ch1,
  output logic wr_control,
  output logic [7:0] wr_data
);
  logic access;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic hit0;
  logic hit1;
  logic hit2;

  // One register per aligned word; unaligned byte addresses are unmapped
  assign access = psel && penable;
  always_comb begin
    hit0 = 1'b0;
    hit1 = 1'b0;
    hit2 = 1'b0;
    if (paddr == {dac_code_ch0_addr, 2'b00}) begin
      hit0 = 1'b1;
    end else if (paddr == {dac_code_ch1_addr, 2'b00}) begin
      hit1 = 1'b1;
    end else if (paddr == {dac_control_addr, 2'b00}) begin
      hit2 = 1'b1;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    wr_code_ch0 = 1'b0;
    wr_code_ch1 = 1'b0;
    wr_control = 1'b0;
    wr_data = pwdata[7:0];
    if (psel && !penable) begin
      if (!(hit0 || hit1 || hit2)) begin
        next_pslverr = 1'b1;
      end
      if (hit0) begin
        next_prdata = {24'h000000, rd_code_ch0};
      end else if (hit1) begin
        next_prdata = {24'h000000, rd_code_ch1};
      end else if (hit2) begin
        next_prdata = {24'h000000, rd_control};
      end
    end else if (access && pwrite && pstrb[0]) begin
      wr_code_ch0 = hit0;
      wr_code_ch1 = hit1;
      wr_control = hit2;
    end
  end

  // Zero wait states: setup cycle prepares read data, access completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_pslverr;
      end else if (!psel) begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule // dac_apb_slave

/* File: logic/dac_channel.sv */
module dac_channel
  import dac_pkg::*;
#(
  parameter int conv_count = conv_cycles
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic convert,
  input wire logic restart,
  output logic busy
);
  logic [15:0] count;
  logic [15:0] next_count;

  // Settling delay of the analog path; restarts on each code write while the channel converts
  always_comb begin
    next_count = count;
    if (clear || !convert) begin
      next_count = 16'h0000;
    end else if (restart) begin
      next_count = 16'(conv_count);
    end else if (count != 16'h0000) begin
      next_count = count - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else begin
      count <= next_count;
    end
  end

  assign busy = (count != 16'h0000);
endmodule // dac_channel

/* File: logic/dac_control_top.sv */
// Overview of operation
// [RULE1] Code registers read/write, clear on reset, standby
// [RULE2] Control register resets to 0x1f
// [RULE3] Bit 7 enables channel 1 conversion and pin
// [RULE4] Bit 6 enables channel 0 conversion and pin
// [RULE5] Bit 5 ties both channels' conversion together
// [RULE6] No enable stops both; joint plus any converts both
// [RULE7] Pin drive follows own enable only
// [RULE8] Control bits 4..0 read one, ignore writes
// [RULE9] Enabled channel converts its code continuously
// [RULE10] New code write restarts conversion at once
// [RULE11] Level is reference times code over 256
// [RULE12] Output holds until new code or disable
// [RULE13] Cleared enable releases pin as input
// [RULE14] Joint bit keeps analog circuitry powered
// [RULE15] Per-channel code, convert, drive outputs to macro
//
// Added by the designer: the APB interface to the registers.
module dac_control_top
  import dac_pkg::*;
#(
  parameter int conv_count = conv_cycles
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic standby,
  input wire logic adc_start_bit,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] analog_out_ch0,
  output logic [7:0] analog_out_ch1,
  output logic convert_ch0,
  output logic convert_ch1,
  output logic analog_out_ch0_oe,
  output logic analog_out_ch1_oe,
  output logic settling_ch0,
  output logic settling_ch1,
  output logic analog_power
);
  logic [7:0] dac_code_ch0;
  logic [7:0] dac_code_ch1;
  logic out_enable_ch1;
  logic out_enable_ch0;
  logic joint_convert_enable;
  logic [7:0] next_code_ch0;
  logic [7:0] next_code_ch1;
  logic next_oe1;
  logic next_oe0;
  logic next_joint;
  logic [7:0] control_view;
  logic wr_code_ch0;
  logic wr_code_ch1;
  logic wr_control;
  logic [7:0] wr_data;
  logic conv0;
  logic conv1;
  logic [1:0] conv_vec;
  logic [1:0] restart_vec;
  logic [1:0] busy_vec;

  assign control_view = {out_enable_ch1, out_enable_ch0, joint_convert_enable, control_reserved}; // RULE8

  dac_apb_slave u_bus (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .rd_code_ch0(dac_code_ch0),
    .rd_code_ch1(dac_code_ch1),
    .rd_control(control_view),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wr_code_ch0(wr_code_ch0),
    .wr_code_ch1(wr_code_ch1),
    .wr_control(wr_control),
    .wr_data(wr_data)
  );

  always_comb begin
    next_code_ch0 = dac_code_ch0;
    next_code_ch1 = dac_code_ch1;
    next_oe1 = out_enable_ch1;
    next_oe0 = out_enable_ch0;
    next_joint = joint_convert_enable;
    if (standby) begin
      next_code_ch0 = code_reset; // RULE1
      next_code_ch1 = code_reset; // RULE1
      next_oe1 = control_reset[out_enable_ch1_bit]; // RULE2
      next_oe0 = control_reset[out_enable_ch0_bit]; // RULE2
      next_joint = control_reset[joint_convert_enable_bit]; // RULE2
    end else begin
      if (wr_code_ch0) begin
        next_code_ch0 = wr_data; // RULE1
      end
      if (wr_code_ch1) begin
        next_code_ch1 = wr_data; // RULE1
      end
      if (wr_control) begin
        next_oe1 = wr_data[out_enable_ch1_bit]; // RULE3
        next_oe0 = wr_data[out_enable_ch0_bit]; // RULE4
        next_joint = wr_data[joint_convert_enable_bit]; // RULE5
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_code_ch0 <= code_reset; // RULE1
      dac_code_ch1 <= code_reset;
      out_enable_ch1 <= control_reset[out_enable_ch1_bit]; // RULE2
      out_enable_ch0 <= control_reset[out_enable_ch0_bit];
      joint_convert_enable <= control_reset[joint_convert_enable_bit];
    end else begin
      dac_code_ch0 <= next_code_ch0;
      dac_code_ch1 <= next_code_ch1;
      out_enable_ch1 <= next_oe1;
      out_enable_ch0 <= next_oe0;
      joint_convert_enable <= next_joint;
    end
  end

  // Conversion enable table
  always_comb begin
    conv0 = out_enable_ch0 || (joint_convert_enable && out_enable_ch1); // RULE4 RULE5 RULE6
    conv1 = out_enable_ch1 || (joint_convert_enable && out_enable_ch0); // RULE3 RULE5 RULE6
  end

  assign conv_vec = {conv1, conv0};
  assign restart_vec = {wr_code_ch1, wr_code_ch0} & {2{!standby}}; // RULE10

  // One settling counter per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    dac_channel #(.conv_count(conv_count)) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .clear(standby),
      .convert(conv_vec[ch]),
      .restart(restart_vec[ch]), // RULE10
      .busy(busy_vec[ch])
    );
  end

  // Registered copies of the macro controls; they trail the registers by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_out_ch0 <= code_reset;
      analog_out_ch1 <= code_reset;
      convert_ch0 <= 1'b0;
      convert_ch1 <= 1'b0;
      analog_out_ch0_oe <= 1'b0;
      analog_out_ch1_oe <= 1'b0;
      settling_ch0 <= 1'b0;
      settling_ch1 <= 1'b0;
      analog_power <= 1'b0;
    end else begin
      // Macro produces reference*code/256; code passes continuously
      analog_out_ch0 <= dac_code_ch0; // RULE9 RULE11 RULE12 RULE15
      analog_out_ch1 <= dac_code_ch1; // RULE9 RULE11 RULE12 RULE15
      convert_ch0 <= conv0; // RULE15
      convert_ch1 <= conv1; // RULE15
      analog_out_ch0_oe <= out_enable_ch0; // RULE7 RULE13
      analog_out_ch1_oe <= out_enable_ch1; // RULE7 RULE13
      settling_ch0 <= busy_vec[0];
      settling_ch1 <= busy_vec[1];
      analog_power <= joint_convert_enable || conv0 || conv1 || adc_start_bit; // RULE14
    end
  end
endmodule // dac_control_top

/* File: test/dac_control_properties.sv */
module dac_control_properties
  import dac_pkg::*;
#(parameter int conv_count = conv_cycles) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [7:0] analog_out_ch0,
  input wire logic convert_ch0,
  input wire logic convert_ch1,
  input wire logic analog_out_ch0_oe,
  input wire logic analog_out_ch1_oe,
  input wire logic settling_ch0,
  input wire logic analog_power
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc;
    psel && penable && pready && !standby;
  endsequence
  sequence wr_ctl;
    acc ##0 pwrite && pstrb[0] && paddr == {dac_control_addr, 2'b00};
  endsequence
  sequence wr_c0;
    acc ##0 pwrite && pstrb[0] && paddr == {dac_code_ch0_addr, 2'b00};
  endsequence
  logic [15:0] cnt, next_cnt;
  // Only bounds one burst; back-to-back writes would stretch it
  always_comb next_cnt = settling_ch0 ? cnt + 16'h1 : 16'h0;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt <= 16'h0;
    else cnt <= next_cnt;
  AST_PREADY: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  AST_RSVD: assert property (acc ##0 !pwrite && paddr == {dac_control_addr, 2'b00} |-> prdata[4:0] == 5'h1f)
    else $error("reserved bits not one");
  AST_CODE: assert property (wr_c0 |-> ##2 analog_out_ch0 == $past(pwdata[7:0], 2))
    else $error("code not applied");
  AST_OE: assert property (wr_ctl |-> ##2 analog_out_ch0_oe == $past(pwdata[6], 2))
    else $error("drive not own bit");
  AST_OFF: assert property (!analog_out_ch0_oe && !analog_out_ch1_oe |-> !convert_ch0 && !convert_ch1)
    else $error("converting while off");
  AST_CONV: assert property (analog_out_ch0_oe |-> convert_ch0)
    else $error("channel 0 idle");
  AST_PWR: assert property (convert_ch0 || convert_ch1 |-> analog_power)
    else $error("power off while converting");
  AST_SETTLE: assert property (wr_c0 ##0 analog_out_ch0_oe |-> ##[1:3] settling_ch0)
    else $error("no restart");
  AST_SETTLE_LEN: assert property (cnt <= 16'(conv_count))
    else $error("settling too long");
  AST_STBY: assert property (standby [*3] |-> analog_out_ch0 == 8'h00 && !convert_ch0)
    else $error("standby no clear");
endmodule // dac_control_properties

/* File: test/dac_pin_load.sv */
module dac_pin_load #(parameter int ref_mv = 3300) (
  input wire logic pclk,
  input wire logic [7:0] code,
  input wire logic drive,
  output int level_mv
);
  timeunit 1ns;
  timeprecision 1ns;
  int last = 0;
  always @(posedge pclk)
    if (drive === 1'b1) last <= ref_mv * code / 256;
  // Released pin floats: show no stale level
  assign level_mv = (drive === 1'b1) ? ref_mv * code / 256 : ~last;
endmodule // dac_pin_load

/* File: test/tb_dac_control_top.sv */
module tb_dac_control_top;
  import dac_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn, standby, adc_start_bit, psel, penable, pwrite, look;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic pready, pslverr, cv0, cv1, oe0, oe1, pw, st0, st1;
  logic [7:0] a0, a1, c0, c1;
  logic a;
  logic [32:0] q[$];
  int lvl0, n, k, fail_count = 0, cmp_count = 0;
  int seed = 32'h3be7cc5b;
  initial forever #10 pclk = ~pclk;
  dac_control_top #(.conv_count(4)) DUT (.pclk(pclk), .presetn(presetn), .standby(standby),
    .adc_start_bit(adc_start_bit), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_out_ch0(a0), .analog_out_ch1(a1), .convert_ch0(cv0), .convert_ch1(cv1),
    .analog_out_ch0_oe(oe0), .analog_out_ch1_oe(oe1), .settling_ch0(st0), .settling_ch1(st1),
    .analog_power(pw));
  dac_pin_load LOAD0 (.pclk(pclk), .code(a0), .drive(oe0), .level_mv(lvl0));
  task end_of_test;
    $display("mismatches %0d compares %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [32:0] s, input logic [32:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [15:0] ad, input logic [7:0] d, input logic [3:0] s);
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {ad, 2'b00};
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rd(input logic [15:0] ad, input logic [7:0] e);
    q.push_back({25'h0, e});
    apb(0, ad, 8'h00, 4'hf);
  endtask
  function automatic logic [32:0] pins(logic [7:0] x0, x1, logic [2:0] b, logic p);
    logic v0, v1;
    v0 = b[1] | (b[0] & b[2]);
    v1 = b[2] | (b[0] & b[1]);
    return {12'h0, x1, x0, v1, v0, b[2], b[1], b[0] | v0 | v1 | p};
  endfunction
  task peek(input logic [32:0] e);
    q.push_back(e);
    look <= 1;
    @(posedge pclk);
    look <= 0;
  endtask
  // Code write to an enabled channel; settling must last the counter length
  task settle(input logic ch);
    apb(1, ch ? dac_code_ch1_addr : dac_code_ch0_addr, 8'h80, 4'h1);
    n = 0;
    while ((ch ? st1 : st0) !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    k = 0;
    while ((ch ? st1 : st0) === 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    check("settle", 33'(k), 33'(4));
  endtask
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
      check("read", {pslverr, pslverr ? 32'h0 : prdata}, q.pop_front());
    if (look === 1'b1) check("pins", {12'h0, a1, a0, cv1, cv0, oe1, oe0, pw}, q.pop_front());
  end
  initial begin
    presetn = 0; standby = 0; adc_start_bit = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; pstrb = 0; look = 0; a = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(dac_code_ch1_addr, code_reset);
    rd(dac_control_addr, control_reset);
    c0 = 8'($random(seed));
    c1 = 8'($random(seed));
    apb(1, dac_code_ch0_addr, c0, 4'h1);
    apb(1, dac_code_ch1_addr, c1, 4'h1);
    apb(1, dac_code_ch0_addr, ~c0, 4'h0);
    rd(dac_code_ch0_addr, c0);
    rd(dac_code_ch1_addr, c1);
    for (int i = 0; i < 8; i++) begin
      a = 1'($random(seed));
      adc_start_bit <= a;
      apb(1, dac_control_addr, {i[2:0], 5'($random(seed))}, 4'h1);
      rd(dac_control_addr, {i[2:0], 5'h1f});
      peek(pins(c0, c1, i[2:0], a));
    end
    settle(1'b0);
    settle(1'b1);
    check("level", 33'(lvl0), 33'(3300 * 128 / 256));
    q.push_back({1'b1, 32'h0});
    apb(0, 16'hfffb, 8'h00, 4'hf);
    standby <= 1;
    repeat (3) @(posedge pclk);
    standby <= 0;
    @(posedge pclk);
    peek(pins(8'h00, 8'h00, 3'h0, a));
    rd(dac_code_ch0_addr, code_reset);
    rd(dac_control_addr, control_reset);
    end_of_test();
  end
endmodule // tb_dac_control_top
bind dac_control_top dac_control_properties #(.conv_count(conv_count)) CHK (.pclk(pclk), .presetn(presetn),
  .standby(standby), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .analog_out_ch0(analog_out_ch0),
  .convert_ch0(convert_ch0), .convert_ch1(convert_ch1), .analog_out_ch0_oe(analog_out_ch0_oe),
  .analog_out_ch1_oe(analog_out_ch1_oe), .settling_ch0(settling_ch0), .analog_power(analog_power));
